// file: hdl/sbc_map.svh
/*
  Constants of the standby controller: settle select codes, reset values
  and wake latencies. Included by the package and directly by the standby module.
*/
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
`define SBC_SETTLE_RESET    3'h4
`define SBC_SETTLE_MAX      3'h4
`define SBC_SETTLE_EXP0     5'h0C
`define SBC_SETTLE_EXP1     5'h0E
`define SBC_SETTLE_EXP2     5'h0F
`define SBC_SETTLE_EXP3     5'h10
`define SBC_SETTLE_EXP4     5'h11
`define SBC_RESET_SETTLE_EXP 5'h11
`define SBC_WAKE_VECTOR_CLKS 4'h8
`define SBC_WAKE_NEXT_CLKS   4'h2
`endif

// file: hdl/sbc_pkg.sv
/*
  Types of the standby controller. Assumes sbc_map.svh on the include path.
*/
package sbc_pkg;
  `include "sbc_map.svh"
  typedef enum logic [1:0] {
    SBC_RUN    = 2'b00,
    SBC_HALT   = 2'b01,
    SBC_STOP   = 2'b10,
    SBC_SETTLE = 2'b11
  } sbc_mode_type;
  typedef enum logic [1:0] {
    SBC_WAKE_NONE   = 2'b00,
    SBC_WAKE_NEXT   = 2'b01,
    SBC_WAKE_VECTOR = 2'b10,
    SBC_WAKE_RESET  = 2'b11
  } sbc_wake_type;
  typedef struct packed {
    logic requestFlag;
    logic requestBlockFlag;
    logic lowRankSelectFlag;
  } sbc_irq_type;
  typedef struct packed {
    sbc_mode_type mode;
    sbc_wake_type wake;
    logic [17:0]  count;
    logic [3:0]   latency;
    logic [2:0]   settleSel;
    logic         resetPend;
    logic         resumeP;
    sbc_wake_type resumeKind;
    logic         subClkRun;
  } sbc_state_type;
endpackage

// file: hdl/sbc_standby.sv
/*
  Standby controller: HALT and STOP entry, release decision and the
  oscillation settle wait. Assumes the CPU core raises one-cycle pulses
  for the halt and stop instructions, and that interrupt inputs and
  flags come from logic on sys_clk; the external reset pin is a pin.
*/
// Our own choices: the address map and the strobed register port.
// What this block does
// - Halt instruction enters HALT from either clock
// - Hold port latches and state during standby
// - Unmasked interrupt ends HALT, vector or continue
// - HALT wake latency nine vectored, three next, one reset
// - Non-maskable interrupt wakes HALT on main clock only, vectored
// - No non-maskable request on subsystem clock
// - Reset pin during HALT ends mode, resets
// - Mask, rank, accept flags choose wake action
// - Stop instruction works only on main clock
// - STOP pulls main oscillator drive pin up
// - Pending unmasked request turns STOP into settle wait, then resume
// - STOP halts main oscillator only, CPU idle
// - STOP freezes async serial port registers
// - Clocked serials run in STOP on external clock
// - Unmasked interrupt ends STOP after settle wait
// - Reset pin in STOP acts after settle wait
// - Settle select codes pick two-power waits
// - In-service rank flag reflects serviced priority
`timescale 1ns/100ps
`include "sbc_map.svh"
module sbc_standby
  import sbc_pkg::*;
#(
  parameter int NUM_IRQ = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              haltExec,
  input  wire logic              stopExec,
  input  wire logic              subClkSel,
  input  wire logic              nmiReq,
  input  wire sbc_irq_type [NUM_IRQ-1:0] irqIn,
  input  wire logic              interruptAcceptFlag,
  input  wire logic              higherRankInService,
  input  wire logic              serialAExtClk,
  input  wire logic              serialBExtClk,
  input  wire logic              resetPin_n,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWdata,
  output logic [7:0]             regRdata,
  output logic                   cpuClkEn,
  output logic                   mainOscEn,
  output logic                   mainOscDrivePullUp,
  output logic                   portLatchHold,
  output logic                   asyncSerialPortEn,
  output logic                   clockedSerialAEn,
  output logic                   clockedSerialBEn,
  output logic                   clockOutputPinLow,
  output logic                   inServiceRankFlag,
  output logic                   resumePulse,
  output sbc_wake_type           resumeKind,
  output logic                   sysReset,
  output sbc_mode_type           modeOut
);
  localparam logic [7:0] ADDR_SETTLE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;

  initial begin
    if (NUM_IRQ < 1 || NUM_IRQ > 64) begin
      $error("NUM_IRQ out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [17:0] settleCycles(input logic [2:0] sel);
    logic [4:0] e;
    e = `SBC_SETTLE_EXP4;
    case (sel)
      3'h0: e = `SBC_SETTLE_EXP0;
      3'h1: e = `SBC_SETTLE_EXP1;
      3'h2: e = `SBC_SETTLE_EXP2;
      3'h3: e = `SBC_SETTLE_EXP3;
      default: e = `SBC_SETTLE_EXP4;
    endcase
    settleCycles = 18'(18'h00001 << e);
  endfunction

  // Decides the action for one maskable request per the flag table.
  function automatic sbc_wake_type maskAction(input sbc_irq_type r,
                                              input logic ie,
                                              input logic in_service_rank_flag);
    maskAction = SBC_WAKE_NONE;
    if (r.requestFlag && !r.requestBlockFlag) begin
      if (!r.lowRankSelectFlag) begin
        maskAction = ie ? SBC_WAKE_VECTOR : SBC_WAKE_NEXT;
      end else begin
        maskAction = (ie && in_service_rank_flag) ? SBC_WAKE_VECTOR : SBC_WAKE_NEXT;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic resetMeta;
  logic resetSync;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resetMeta <= 1'b0;
      resetSync <= 1'b0;
    end else begin
      resetMeta <= ~resetPin_n;
      resetSync <= resetMeta;
    end
  end

  // Rank flag: 1 unless a higher-priority interrupt is in service.
  assign inServiceRankFlag = ~higherRankInService;

  sbc_wake_type maskWake;
  logic         nmiValid;
  always_comb begin
    maskWake = SBC_WAKE_NONE;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (maskAction(irqIn[i], interruptAcceptFlag, inServiceRankFlag)
          == SBC_WAKE_VECTOR) begin
        maskWake = SBC_WAKE_VECTOR;
      end else if (maskWake == SBC_WAKE_NONE) begin
        maskWake = maskAction(irqIn[i], interruptAcceptFlag,
                              inServiceRankFlag);
      end
    end
  end
  // The non-maskable source is silent on the subsystem clock.
  assign nmiValid = nmiReq & ~subClkSel;

  ////////////////////////////////////////////////////////////////////////
  sbc_state_type s_q;
  sbc_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.resumeP = 1'b0;
    s_d.subClkRun = subClkSel;
    if (regWrite && regAddr == ADDR_SETTLE) begin
      // Prohibited codes are refused so the wait stays defined.
      if (regWdata[2:0] <= `SBC_SETTLE_MAX) begin
        s_d.settleSel = regWdata[2:0];
      end
    end
    case (s_q.mode)
      SBC_RUN: begin
        if (s_q.latency != 4'h0) begin
          s_d.latency = s_q.latency - 4'h1;
          if (s_q.latency == 4'h1) begin
            s_d.resumeP = 1'b1;
            s_d.resumeKind = s_q.wake;
          end
        end else if (stopExec && !subClkSel) begin
          if (maskWake != SBC_WAKE_NONE) begin
            // A pending request clears STOP at once; wait then resume.
            s_d.mode = SBC_SETTLE;
            s_d.wake = maskWake;
            s_d.count = settleCycles(s_q.settleSel);
          end else begin
            s_d.mode = SBC_STOP;
          end
        end else if (haltExec) begin
          s_d.mode = SBC_HALT;
        end
      end
      SBC_HALT: begin
        if (resetSync) begin
          s_d.mode = SBC_RUN;
          s_d.wake = SBC_WAKE_RESET;
          s_d.latency = 4'h1;
        end else if (nmiValid) begin
          s_d.mode = SBC_RUN;
          s_d.wake = SBC_WAKE_VECTOR;
          s_d.latency = `SBC_WAKE_VECTOR_CLKS + 4'h1;
        end else if (maskWake != SBC_WAKE_NONE) begin
          s_d.mode = SBC_RUN;
          s_d.wake = maskWake;
          s_d.latency = (maskWake == SBC_WAKE_VECTOR) ?
                        `SBC_WAKE_VECTOR_CLKS + 4'h1 :
                        `SBC_WAKE_NEXT_CLKS + 4'h1;
        end
      end
      SBC_STOP: begin
        if (resetSync) begin
          s_d.mode = SBC_SETTLE;
          s_d.wake = SBC_WAKE_RESET;
          s_d.count = 18'(18'h00001 << `SBC_RESET_SETTLE_EXP);
        end else if (maskWake != SBC_WAKE_NONE) begin
          s_d.mode = SBC_SETTLE;
          s_d.wake = maskWake;
          s_d.count = settleCycles(s_q.settleSel);
        end
      end
      SBC_SETTLE: begin
        if (s_q.count <= 18'h00001) begin
          s_d.mode = SBC_RUN;
          s_d.count = 18'h00000;
          s_d.resumeP = 1'b1;
          s_d.resumeKind = s_q.wake;
        end else begin
          s_d.count = s_q.count - 18'h00001;
        end
      end
      default: s_d.mode = SBC_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{mode: SBC_RUN, wake: SBC_WAKE_NONE, count: 18'h00000,
               latency: 4'h0, settleSel: `SBC_SETTLE_RESET,
               resetPend: 1'b0, resumeP: 1'b0,
               resumeKind: SBC_WAKE_NONE, subClkRun: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic stopLike;
  assign stopLike = (s_q.mode == SBC_STOP) || (s_q.mode == SBC_SETTLE);
  assign modeOut    = s_q.mode;
  assign cpuClkEn   = (s_q.mode == SBC_RUN);
  assign mainOscEn  = !stopLike;
  assign mainOscDrivePullUp = (s_q.mode == SBC_STOP);
  // Outputs only freeze; the latches themselves are never touched here.
  assign portLatchHold = (s_q.mode != SBC_RUN);
  assign asyncSerialPortEn = !stopLike;
  assign clockedSerialAEn = !stopLike || serialAExtClk;
  assign clockedSerialBEn = !stopLike || serialBExtClk;
  assign clockOutputPinLow = stopLike;
  assign resumePulse = s_q.resumeP;
  assign resumeKind  = s_q.resumeKind;
  assign sysReset    = s_q.resumeP && s_q.resumeKind == SBC_WAKE_RESET;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        ADDR_SETTLE: regRdata <= {5'h00, s_q.settleSel};
        ADDR_STATUS: regRdata <= {3'h0, inServiceRankFlag, s_q.subClkRun,
                                  1'b0, s_q.mode};
        default:     regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule

// file: tb/sbc_cpu_model.sv
/* CPU core and interrupt request model for the standby controller.
   Assumes the bench gives one-cycle commands after clock edges. */
`timescale 1ns/100ps
module sbc_cpu_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic cmdHalt,
  input  wire logic cmdStop,
  input  wire logic raiseReq,
  input  wire logic resumePulse,
  output logic      haltExec,
  output logic      stopExec,
  output logic      reqFlag
);
  //////////////////////////////
  // The bench idles after each resume, as a no-op after a halt would.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      haltExec <= 1'b0;
      stopExec <= 1'b0;
      reqFlag <= 1'b0;
    end else begin
      haltExec <= cmdHalt;
      stopExec <= cmdStop;
      reqFlag <= raiseReq | (reqFlag & ~resumePulse);
    end
  end
endmodule

// file: tb/sbc_standby_sva.sv
/* Port checker of the standby controller.
   Assumes binding to sbc_standby; sees its ports only. */
`timescale 1ns/100ps
module sbc_standby_sva
  import sbc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic haltExec,
  input wire logic stopExec,
  input wire logic subClkSel,
  input wire logic higherRankInService,
  input wire logic serialAExtClk,
  input wire logic serialBExtClk,
  input wire logic cpuClkEn,
  input wire logic mainOscEn,
  input wire logic mainOscDrivePullUp,
  input wire logic asyncSerialPortEn,
  input wire logic clockedSerialAEn,
  input wire logic clockedSerialBEn,
  input wire logic inServiceRankFlag,
  input wire logic resumePulse,
  input wire sbc_wake_type resumeKind,
  input wire sbc_mode_type modeOut
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  //////////////////////////////
  run_clock_a: assert property (cpuClkEn == (modeOut == SBC_RUN))
    else $error("cpu clock enable wrong");
  halt_entry_a: assert property (modeOut == SBC_HALT &&
    $past(modeOut) == SBC_RUN |-> $past(haltExec) || $past(stopExec))
    else $error("halt without instruction");
  halt_wake_a: assert property ($past(modeOut) == SBC_HALT &&
    modeOut == SBC_RUN |-> ##[1:9] resumePulse)
    else $error("late resume after halt");
  stop_sub_a: assert property (stopExec && subClkSel |=>
    modeOut != SBC_STOP) else $error("stop on subsystem clock");
  pull_up_a: assert property (mainOscDrivePullUp ==
    (modeOut == SBC_STOP)) else $error("pull-up wrong");
  stop_osc_a: assert property (modeOut == SBC_STOP |-> !mainOscEn &&
    !asyncSerialPortEn && clockedSerialAEn == serialAExtClk &&
    clockedSerialBEn == serialBExtClk) else $error("stop enables wrong");
  rank_flag_a: assert property (inServiceRankFlag ==
    !higherRankInService) else $error("rank flag wrong");
  pulse_once_a: assert property (resumePulse |=> !resumePulse)
    else $error("resume pulse too long");
  cover property ($past(modeOut) == SBC_HALT && modeOut == SBC_RUN);
  cover property (modeOut == SBC_STOP);
  cover property (resumePulse && resumeKind == SBC_WAKE_NEXT);
endmodule
bind sbc_standby sbc_standby_sva u_sva (.*);

// file: tb/sbc_standby_bench.sv
/* Bench of the standby controller with a CPU model.
   Assumes sbc_pkg and the checker are compiled first. */
`timescale 1ns/100ps
module sbc_standby_bench;
  import sbc_pkg::*;
  logic sys_clk = 0, rst = 1, subClkSel = 0, nmiReq = 0, d0;
  logic interruptAcceptFlag = 0, higherRankInService = 0, raise = 0;
  logic serialAExtClk = 0, serialBExtClk = 0, resetPin_n = 1;
  logic regWrite = 0, regRead = 0, cmdHalt = 0, cmdStop = 0, blk = 0;
  logic [7:0] regAddr = 0, regWdata = 0, regRdata, d;
  logic haltExec, stopExec, reqFlag, low = 0, cpuClkEn, mainOscEn;
  logic mainOscDrivePullUp, portLatchHold, asyncSerialPortEn, sysReset;
  logic clockedSerialAEn, clockedSerialBEn, clockOutputPinLow;
  logic inServiceRankFlag, resumePulse;
  sbc_wake_type resumeKind;
  sbc_mode_type modeOut;
  sbc_irq_type [7:0] irqIn;
  // Rows: nmi, mask, low rank, accept, higher in service, wake kind.
  logic [6:0] rows [7] = '{7'h01, 7'h0A, 7'h11, 7'h1D, 7'h1A, 7'h28, 7'h62};
  int num_errors = 0, tests_run = 0, cyc = 0, n;
  assign irqIn = {21'h0, reqFlag, blk, low};
  sbc_standby DUT (.*);
  sbc_cpu_model cpu (.sys_clk(sys_clk), .rst(rst), .cmdHalt(cmdHalt),
    .cmdStop(cmdStop), .raiseReq(raise), .resumePulse(resumePulse),
    .haltExec(haltExec), .stopExec(stopExec), .reqFlag(reqFlag));
  //////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmd(input bit stop);
    @(posedge sys_clk);
    cmdHalt <= !stop;
    cmdStop <= stop;
    @(posedge sys_clk);
    cmdHalt <= 0;
    cmdStop <= 0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_pulse(input int lim);
    n = 0;
    while (resumePulse !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic reg_io(input bit wr, input logic [7:0] a, w);
    @(posedge sys_clk);
    regWrite <= wr;
    regRead <= !wr;
    regAddr <= a;
    regWdata <= w;
    @(posedge sys_clk);
    regWrite <= 0;
    regRead <= 0;
    #1 d = regRdata;
  endtask
  //////////////////////////////
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    #1;
    chk(modeOut, SBC_RUN);
    chk(regRdata, 8'h00);
    foreach (rows[i]) begin
      cmd(0);
      chk(modeOut, SBC_HALT);
      chk(portLatchHold, 1'b1);
      @(posedge sys_clk);
      raise <= 1;
      nmiReq <= rows[i][6];
      blk <= rows[i][5];
      low <= rows[i][4];
      interruptAcceptFlag <= rows[i][3];
      higherRankInService <= rows[i][2];
      @(posedge sys_clk);
      raise <= 0;
      #1;
      wait_pulse(12);
      n = n + rows[i][6];
      if (rows[i][1:0] == 2'h0) begin
        chk(modeOut, SBC_HALT);
        @(posedge sys_clk);
        nmiReq <= 1;
        wait_pulse(14);
        chk(resumeKind, SBC_WAKE_VECTOR);
      end else begin
        chk(resumeKind, rows[i][1:0]);
        chk(n, rows[i][1] ? 10 : 4);
      end
      @(posedge sys_clk);
      nmiReq <= 0;
      blk <= 0;
      repeat (3) @(posedge sys_clk);
      $display("row %0d done", i);
    end
    @(posedge sys_clk);
    subClkSel <= 1;
    cmd(1);
    chk(modeOut, SBC_RUN);
    cmd(0);
    chk(modeOut, SBC_HALT);
    @(posedge sys_clk);
    nmiReq <= 1;
    wait_pulse(12);
    chk(modeOut, SBC_HALT);
    @(posedge sys_clk);
    resetPin_n <= 0;
    wait_pulse(12);
    chk(resumeKind, SBC_WAKE_RESET);
    chk(sysReset, 1'b1);
    @(posedge sys_clk);
    resetPin_n <= 1;
    nmiReq <= 0;
    subClkSel <= 0;
    $display("subclock done");
    reg_io(0, 8'h00, 8'h00);
    chk(d, 8'h04);
    reg_io(1, 8'h00, 8'h05);
    reg_io(0, 8'h00, 8'h00);
    chk(d, 8'h04);
    reg_io(1, 8'h00, 8'h00);
    reg_io(0, 8'h00, 8'h00);
    chk(d, 8'h00);
    reg_io(0, 8'h7F, 8'h00);
    chk(d, 8'h00);
    reg_io(0, 8'h01, 8'h00);
    chk(d, 8'h10);
    $display("registers done");
    @(posedge sys_clk);
    serialAExtClk <= 1;
    interruptAcceptFlag <= 1;
    cmd(1);
    chk(modeOut, SBC_STOP);
    chk({mainOscDrivePullUp, clockedSerialAEn}, 2'h3);
    chk({clockedSerialBEn, clockOutputPinLow, asyncSerialPortEn,
         mainOscEn}, 4'h4);
    @(posedge sys_clk);
    raise <= 1;
    @(posedge sys_clk);
    raise <= 0;
    #1;
    wait_pulse(4300);
    d0 = n >= 4096;
    chk(d0, 1'b1);
    chk(resumeKind, SBC_WAKE_VECTOR);
    $display("stop done");
    conclude();
  end
endmodule
